// ===== logic/ana_defs.svh
// Purpose: named constants of the auto-negotiation ability register bank
// Assumes: included by bare name from the package and the modules
// Notes:   register indices are word indices; byte address is four times the index
`ifndef ANA_DEFS_SVH
`define ANA_DEFS_SVH

`define ANA_ADDR_W        8
`define ANA_IDX_W         6
`define ANA_IDX_ADV       6'h04
`define ANA_IDX_LP        6'h05
`define ANA_IDX_STAT      6'h06
`define ANA_SEL_IEEE8023  5'h01
`define ANA_ADV_RESET     16'h0001
`define ANA_ADV_WMASK     16'hBFFF
`define ANA_LP_RESET      16'h0000
`define ANA_HALF_ZERO     16'h0000
`define ANA_WORD_ZERO     32'h00000000
`define ANA_STAT_PAD      31'h00000000
`define ANA_STAT_PAGE     0
`define ANA_TECH_PINS     4
`define ANA_SETTLE_CYC    3'h4
`define ANA_CNT_ZERO      3'h0
`define ANA_CNT_ONE       3'h1
`define ANA_RESP_OKAY     2'h0
`define ANA_RESP_SLVERR   2'h2

`endif

// ===== logic/ana_pkg.sv
// Purpose: shared types of the auto-negotiation ability register bank
// Assumes: constants come from ana_defs.svh
// Notes:   page layout follows the base page link code word, msb first
`include "ana_defs.svh"
`default_nettype none

package ana_pkg;

    typedef struct packed {
        logic                    next_page;
        logic                    ack;
        logic                    remote_fault;
        logic                    rsvd12;
        logic                    asym_pause;
        logic                    pause;
        logic                    ab_100t4;
        logic                    ab_100tx_fd;
        logic                    ab_100tx;
        logic                    ab_10t_fd;
        logic                    ab_10t;
        logic [4:0]              selector;
    } ana_page_t;

    typedef struct packed {
        logic                    valid;
        logic                    is_next;
        ana_page_t               word;
    } ana_rx_page_t;

    typedef struct packed {
        logic                    en;
        logic [`ANA_IDX_W-1:0]   idx;
        logic [31:0]             data;
        logic [3:0]              strb;
    } ana_wr_t;

endpackage

`default_nettype wire

// ===== logic/ana_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for strap pins
// Assumes: pins are quasi-static levels from outside the clock domain
// Notes:   a bit changes only once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
`include "ana_defs.svh"

module ana_pin_sync
    import ana_pkg::*;
#(
    parameter int W = `ANA_TECH_PINS
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] pin_async,
    output var  logic [W-1:0] pin_level
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge ref_clk) begin
        stage1 <= reset ? '0 : pin_async;
        stage2 <= reset ? '0 : stage1;
        stage3 <= reset ? '0 : stage2;
    end

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_filt
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    pin_level[g] <= 1'b0;
                end else if (stage2[g] == stage3[g]) begin
                    pin_level[g] <= stage3[g];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ===== logic/ana_axil_slave.sv
// Purpose: AXI4-Lite slave front end for a small word-indexed register file
// Assumes: register file decodes indices combinationally and answers ok flags
// Notes:   one write and one read in flight; every bus output is a flop
`timescale 1ns/100ps
`default_nettype none
`include "ana_defs.svh"

module ana_axil_slave
    import ana_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic [`ANA_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output var  logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output var  logic                  s_axi_wready,
    output var  logic [1:0]            s_axi_bresp,
    output var  logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [`ANA_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output var  logic                  s_axi_arready,
    output var  logic [31:0]           s_axi_rdata,
    output var  logic [1:0]            s_axi_rresp,
    output var  logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output var  ana_wr_t               wr,
    input  wire logic                  wr_ok,
    output var  logic [`ANA_IDX_W-1:0] rd_idx,
    input  wire logic [31:0]           rd_word,
    input  wire logic                  rd_ok
);

    logic [`ANA_IDX_W-1:0] aw_idx;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;

    wire logic aw_take = s_axi_awvalid & s_axi_awready;
    wire logic w_take  = s_axi_wvalid & s_axi_wready;
    wire logic b_done  = s_axi_bvalid & s_axi_bready;
    wire logic ar_take = s_axi_arvalid & s_axi_arready;
    wire logic r_done  = s_axi_rvalid & s_axi_rready;
    // both halves held and no response pending: commit now
    wire logic commit  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

    assign wr     = '{en: commit, idx: aw_idx, data: w_data, strb: w_strb};
    assign rd_idx = s_axi_araddr[`ANA_ADDR_W-1:2];

    always_ff @(posedge ref_clk) begin
        if (aw_take) begin
            aw_idx <= s_axi_awaddr[`ANA_ADDR_W-1:2];
        end
        if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ANA_RESP_OKAY;
        end else begin
            s_axi_awready <= b_done | (s_axi_awready & ~aw_take);
            s_axi_wready  <= b_done | (s_axi_wready & ~w_take);
            s_axi_bvalid  <= commit | (s_axi_bvalid & ~s_axi_bready);
            if (commit) begin
                s_axi_bresp <= wr_ok ? `ANA_RESP_OKAY : `ANA_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `ANA_WORD_ZERO;
            s_axi_rresp   <= `ANA_RESP_OKAY;
        end else begin
            s_axi_arready <= r_done | (s_axi_arready & ~ar_take);
            s_axi_rvalid  <= ar_take | (s_axi_rvalid & ~s_axi_rready);
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? `ANA_RESP_OKAY : `ANA_RESP_SLVERR;
            end
        end
    end

endmodule

`default_nettype wire

// ===== logic/ana_ability_regs.sv
// Purpose: auto-negotiation base page ability registers of one port
// Assumes: rx_page comes from negotiation logic on ref_clk; straps are async pins
// Notes:   local advertisement at index 4, partner base page at index 5, status at 6
//
// Operation
// - advertise four-pair 100 Mb bit is writable and sent although unsupported.
// - advertisement bits 8..5 are writable technology abilities, one means advertised.
// - the four technology ability defaults come from strap pins after reset.
// - five-bit selector is writable and resets to the 802.3 code 00001.
// - partner register is read-only, resets to zero, bit 15 shows next page.
// - partner bit 14 shows the partner acknowledged our code word.
// - partner bits 13, 11 and 10 show fault, asymmetric pause and pause.
// - partner bits 9..5 show remote technology abilities in local order.
// - partner low five bits hold the received selector, resetting to zero.
// - next pages never overwrite the partner base page register.
// - a received base page loads the partner register and flags reception.
// - advertisement pause bit is writable and resets to zero.
`timescale 1ns/100ps
`default_nettype none
`include "ana_defs.svh"

module ana_ability_regs
    import ana_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire logic [`ANA_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output var  logic                    s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output var  logic                    s_axi_wready,
    output var  logic [1:0]              s_axi_bresp,
    output var  logic                    s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`ANA_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output var  logic                    s_axi_arready,
    output var  logic [31:0]             s_axi_rdata,
    output var  logic [1:0]              s_axi_rresp,
    output var  logic                    s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic [`ANA_TECH_PINS-1:0] cfg_ability_pins,
    input  wire ana_rx_page_t            rx_page,
    output var  ana_page_t               tx_base_page,
    output var  logic                    page_received
);

    function automatic logic ana_hit(input logic [`ANA_IDX_W-1:0] idx,
                                     input logic [`ANA_IDX_W-1:0] reg_idx);
        ana_hit = (idx == reg_idx);
    endfunction

    function automatic logic [15:0] ana_merge(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
        logic [15:0] lanes;
        lanes[7:0]  = strb[0] ? data[7:0] : old[7:0];
        lanes[15:8] = strb[1] ? data[15:8] : old[15:8];
        ana_merge = lanes;
    endfunction

    ana_wr_t               wr;
    logic                  wr_ok;
    logic [`ANA_IDX_W-1:0] rd_idx;
    logic [31:0]           rd_word;
    logic                  rd_ok;
    logic [`ANA_TECH_PINS-1:0] pin_level;

    ana_page_t             adv;
    ana_page_t             next_adv;
    ana_page_t             lp;
    ana_page_t             next_lp;
    logic                  page_flag;
    logic                  next_page_flag;
    logic [2:0]            settle_cnt;
    logic                  defaults_done;

    ana_axil_slave u_bus (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr            (wr),
        .wr_ok         (wr_ok),
        .rd_idx        (rd_idx),
        .rd_word       (rd_word),
        .rd_ok         (rd_ok)
    );

    ana_pin_sync #(
        .W (`ANA_TECH_PINS)
    ) u_straps (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .pin_async (cfg_ability_pins),
        .pin_level (pin_level)
    );

    // write decode
    wire logic adv_wr  = wr.en & ana_hit(wr.idx, `ANA_IDX_ADV);
    wire logic lp_wr   = wr.en & ana_hit(wr.idx, `ANA_IDX_LP);
    wire logic stat_wr = wr.en & ana_hit(wr.idx, `ANA_IDX_STAT);
    assign wr_ok = adv_wr | lp_wr | stat_wr;

    // read decode
    wire logic rd_adv  = ana_hit(rd_idx, `ANA_IDX_ADV);
    wire logic rd_lp   = ana_hit(rd_idx, `ANA_IDX_LP);
    wire logic rd_stat = ana_hit(rd_idx, `ANA_IDX_STAT);
    assign rd_ok   = rd_adv | rd_lp | rd_stat;
    assign rd_word = rd_adv  ? {`ANA_HALF_ZERO, adv} :
                     rd_lp   ? {`ANA_HALF_ZERO, lp} :
                     rd_stat ? {`ANA_STAT_PAD, page_flag} :
                               `ANA_WORD_ZERO;

    // bit 14 stays read-only zero through the mask
    // four-pair bit writable
    wire logic [15:0] adv_merged = ana_merge(adv, wr.data, wr.strb);
    wire logic [15:0] adv_masked = (adv_merged & `ANA_ADV_WMASK) | (adv & ~`ANA_ADV_WMASK);

    // straps are read only once the filter has seen a full chain of samples
    wire logic settled       = (settle_cnt == `ANA_SETTLE_CYC);
    wire logic load_defaults = settled & ~defaults_done;

    always_comb begin
        next_adv = adv;
        if (adv_wr) begin
            next_adv = adv_masked;
        end
        if (load_defaults) begin
            {next_adv.ab_100tx_fd, next_adv.ab_100tx, next_adv.ab_10t_fd, next_adv.ab_10t} = pin_level;
        end
    end

    wire logic base_rx = rx_page.valid & ~rx_page.is_next;
    wire logic stat_clr = stat_wr & wr.strb[0] & wr.data[`ANA_STAT_PAGE];

    assign next_lp = base_rx ? rx_page.word : lp;

    assign next_page_flag = base_rx | (page_flag & ~stat_clr);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            adv <= `ANA_ADV_RESET;
        end else begin
            adv <= next_adv;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lp        <= `ANA_LP_RESET;
            page_flag <= 1'b0;
        end else begin
            lp        <= next_lp;
            page_flag <= next_page_flag;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            settle_cnt    <= `ANA_CNT_ZERO;
            defaults_done <= 1'b0;
        end else begin
            settle_cnt    <= settled ? settle_cnt : settle_cnt + `ANA_CNT_ONE;
            defaults_done <= defaults_done | load_defaults;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_base_page  <= `ANA_ADV_RESET;
            page_received <= 1'b0;
        end else begin
            tx_base_page  <= adv;
            page_received <= page_flag;
        end
    end

    a_sel_reset_code: assert property (@(posedge ref_clk)
        reset |=> (adv.selector == `ANA_SEL_IEEE8023))
        else $error("selector not 802.3 after reset");

    a_pause_reset_zero: assert property (@(posedge ref_clk)
        reset |=> (!adv.pause && !adv.asym_pause))
        else $error("pause bits not zero after reset");

    a_straps_load: assert property (@(posedge ref_clk) disable iff (reset)
        load_defaults |=> ({adv.ab_100tx_fd, adv.ab_100tx, adv.ab_10t_fd, adv.ab_10t} == $past(pin_level)))
        else $error("technology defaults not taken from straps");

    a_straps_timely: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(reset) |-> ##[3:5] defaults_done)
        else $error("strap defaults not loaded in time");

    a_t4_write: assert property (@(posedge ref_clk) disable iff (reset)
        (adv_wr && wr.strb[1] && !load_defaults) |=> (adv.ab_100t4 == $past(wr.data[9])) ##1
        (tx_base_page.ab_100t4 == $past(adv.ab_100t4)))
        else $error("four-pair bit not written or not sent");

    a_tech_write: assert property (@(posedge ref_clk) disable iff (reset)
        (adv_wr && wr.strb[0] && wr.strb[1] && !load_defaults) |=>
        (adv[8:5] == $past(wr.data[8:5])) && !adv.rsvd12 == !$past(wr.data[12]) && !adv.ack)
        else $error("advertisement write not applied");

    a_lp_capture: assert property (@(posedge ref_clk) disable iff (reset)
        base_rx |=> (lp == $past(rx_page.word)) && page_flag ##1 page_received)
        else $error("base page not captured or not flagged");

    a_next_ignored: assert property (@(posedge ref_clk) disable iff (reset)
        (rx_page.valid && rx_page.is_next) |=> $stable(lp))
        else $error("next page overwrote partner register");

    a_lp_ro_write: assert property (@(posedge ref_clk) disable iff (reset)
        (lp_wr && !base_rx) |=> $stable(lp))
        else $error("software write changed partner register");

    a_lp_reset_zero: assert property (@(posedge ref_clk)
        reset |=> (lp == `ANA_LP_RESET) && !page_flag)
        else $error("partner register not zero after reset");

    a_flag_clear: assert property (@(posedge ref_clk) disable iff (reset)
        (stat_clr && !base_rx) |=> !page_flag)
        else $error("page flag not cleared by write one");

    a_sel_write: assert property (@(posedge ref_clk) disable iff (reset)
        (adv_wr && wr.strb[0] && !load_defaults) |=> (adv.selector == $past(wr.data[4:0])))
        else $error("selector write not applied");

    a_pause_write: assert property (@(posedge ref_clk) disable iff (reset)
        (adv_wr && wr.strb[1]) |=> (adv.pause == $past(wr.data[10])))
        else $error("pause bit write not applied");

    a_ack_bit_zero: assert property (@(posedge ref_clk) disable iff (reset)
        adv_wr |=> !adv.ack)
        else $error("reserved advertisement bit became set");

    a_tx_mirror: assert property (@(posedge ref_clk) disable iff (reset)
        1'b1 |=> (tx_base_page == $past(adv)))
        else $error("sent base page does not follow advertisement");

    a_flag_mirror: assert property (@(posedge ref_clk) disable iff (reset)
        1'b1 |=> (page_received == $past(page_flag)))
        else $error("page received output does not follow flag");

    a_lp_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !base_rx |=> $stable(lp))
        else $error("partner register changed without a base page");

    a_lp_ack: assert property (@(posedge ref_clk) disable iff (reset)
        base_rx |=> (lp.ack == $past(rx_page.word.ack)))
        else $error("partner acknowledge bit not captured");

    a_lp_cond: assert property (@(posedge ref_clk) disable iff (reset)
        base_rx |=> (lp.remote_fault == $past(rx_page.word.remote_fault)) &&
        (lp.asym_pause == $past(rx_page.word.asym_pause)) && (lp.pause == $past(rx_page.word.pause)))
        else $error("partner fault or pause bits not captured");

    a_lp_tech: assert property (@(posedge ref_clk) disable iff (reset)
        base_rx |=> (lp[9:5] == $past(rx_page.word[9:5])))
        else $error("partner technology bits not captured");

    a_lp_sel: assert property (@(posedge ref_clk) disable iff (reset)
        base_rx |=> (lp.selector == $past(rx_page.word.selector)))
        else $error("partner selector not captured");

    a_strap_once: assert property (@(posedge ref_clk) disable iff (reset)
        (defaults_done && !adv_wr) |=> $stable(adv[8:5]))
        else $error("strap defaults applied more than once");

    a_settle_sat: assert property (@(posedge ref_clk) disable iff (reset)
        settled |=> settled)
        else $error("settle counter left its end value");

endmodule

`default_nettype wire

// ===== verif/ana_link_partner.sv
// Purpose: remote link partner model feeding received pages to the register bank
// Assumes: one page word a pulse on ref_clk, driven right after a rising edge
// Notes:   between pulses the word shows the inverse of the last one, never a stale copy
`timescale 1ns/100ps
`default_nettype none

module ana_link_partner
    import ana_pkg::*;
(
    input  wire logic         ref_clk,
    output var  ana_rx_page_t rx_page
);
    initial rx_page = '0;

    // one-cycle pulse per page, base or next
    task automatic send_page(input ana_page_t w, input logic nxt);
        @(posedge ref_clk);
        rx_page <= '{valid: 1'b1, is_next: nxt, word: w};
        @(posedge ref_clk);
        // released word must not look like a valid repeat
        rx_page <= '{valid: 1'b0, is_next: ~nxt, word: ~w};
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_autoneg_ability_registers.sv
// Purpose: self-checking bench for the ability register bank
// Assumes: AXI4-Lite master tasks, partner model drives rx_page
// Notes:   reference model kept in plain integers
`timescale 1ns/100ps
`default_nettype none
`include "ana_defs.svh"

module tb_autoneg_ability_registers
    import ana_pkg::*;
;
    logic                  ref_clk;
    logic                  reset;
    logic [7:0]            awaddr, araddr;
    logic                  awvalid, wvalid, bready, arvalid, rready;
    logic                  awready, wready, bvalid, arready, rvalid;
    logic [31:0]           wdata, rdata;
    logic [3:0]            wstrb;
    logic [1:0]            bresp, rresp;
    logic [3:0]            pins;
    ana_rx_page_t          rx_page;
    ana_page_t             tx_base_page;
    logic                  page_received;
    int                    fail_count, checks;
    int                    adv_m, lp_m, stat_m;
    logic [31:0]           d;
    logic [1:0]            r;

    localparam logic [7:0] ADV  = {`ANA_IDX_ADV, 2'b00};
    localparam logic [7:0] LP   = {`ANA_IDX_LP, 2'b00};
    localparam logic [7:0] STAT = {`ANA_IDX_STAT, 2'b00};

    ana_ability_regs u_dut (
        .ref_clk(ref_clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cfg_ability_pins(pins), .rx_page(rx_page), .tx_base_page(tx_base_page),
        .page_received(page_received)
    );

    ana_link_partner u_partner (.ref_clk(ref_clk), .rx_page(rx_page));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] s, output logic [1:0] rs);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge ref_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= dat;
        wstrb <= s;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        // bready stays high throughout, so the answer is taken where it is seen
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        rs = bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        dat = rdata;
        rs = rresp;
    endtask

    task automatic check_all();
        rd(ADV, d, r);
        check_val(d, adv_m);
        check_resp(r, `ANA_RESP_OKAY);
        rd(LP, d, r);
        check_val(d, lp_m);
        rd(STAT, d, r);
        check_val(d, stat_m);
        check_val({16'h0000, tx_base_page}, adv_m);
    endtask

    task automatic report_and_stop();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        int m;
        logic nxt;
        ana_page_t w;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, arvalid} = 3'b000;
        bready = 1'b1;
        rready = 1'b1;
        reset = 1'b1;
        fail_count = 0;
        checks = 0;
        void'($urandom(32'h1821D81B));
        pins = 4'($urandom());
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (8) @(posedge ref_clk);
        adv_m = 1 | (int'(pins) << 5);
        lp_m = 0;
        stat_m = 0;
        check_all();
        // writable bits, selector codes and a single-lane write
        for (int i = 0; i < 6; i++) begin
            d = $urandom();
            d[4:0] = (i % 2) ? 5'h02 : `ANA_SEL_IEEE8023;
            if (i == 0)
                d[10:9] = 2'b11;
            m = (i == 5) ? 32'h0000FF00 : 32'h0000FFFF;
            m = m & `ANA_ADV_WMASK;
            wr(ADV, d, (i == 5) ? 4'h2 : 4'hF, r);
            check_resp(r, `ANA_RESP_OKAY);
            adv_m = (adv_m & ~m) | (d & m);
            check_all();
        end
        // base pages stored, next page ignored
        for (int j = 0; j < 4; j++) begin
            w = ana_page_t'(16'($urandom()));
            nxt = (j == 2);
            u_partner.send_page(w, nxt);
            if (!nxt) begin
                lp_m = int'(w);
                stat_m = 1;
            end
            @(posedge ref_clk);
            #1;
            check_val({31'h0, page_received}, stat_m);
            check_all();
        end
        wr(LP, $urandom(), 4'hF, r);
        check_resp(r, `ANA_RESP_OKAY);
        check_all();
        wr(STAT, 32'h1, 4'hF, r);
        stat_m = 0;
        #1;
        check_val({31'h0, page_received}, stat_m);
        wr(8'h3C, $urandom(), 4'hF, r);
        check_resp(r, `ANA_RESP_SLVERR);
        rd(8'h3C, d, r);
        check_val(d, 0);
        check_resp(r, `ANA_RESP_SLVERR);
        check_all();
        // second reset with new straps clears captured partner state
        @(posedge ref_clk);
        reset <= 1'b1;
        pins <= ~pins;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (8) @(posedge ref_clk);
        adv_m = 1 | (int'(pins) << 5);
        lp_m = 0;
        stat_m = 0;
        check_all();
        report_and_stop();
    end
endmodule
`default_nettype wire
